// File: hw/ati_regs.svh
/*
 * Register offsets, field positions, reset values for the angular timer
 * interrupt logic. Assumes a 32-bit AHB-Lite slave, one register per word.
 */
`ifndef ATI_REGS_SVH
`define ATI_REGS_SVH

`define ATI_OFF_EVT_EN 8'h00
`define ATI_OFF_EVT_FLAG 8'h04
`define ATI_OFF_CC_EN 8'h08
`define ATI_OFF_CC_FLAG 8'h0c
`define ATI_OFF_SUMMARY 8'h10
`define ATI_OFF_PERIPH_EN 8'h14
`define ATI_OFF_MODE 8'h18
`define ATI_OFF_CMP1 8'h20
`define ATI_OFF_CMP2 8'h24
`define ATI_OFF_CMP3 8'h28
`define ATI_OFF_CAP1 8'h30
`define ATI_OFF_CAP2 8'h34
`define ATI_OFF_CAP3 8'h38

`define ATI_BIT_PERIOD 0
`define ATI_BIT_PHASE 1
`define ATI_BIT_MISSING 2
`define ATI_BIT_SUMMARY 0
`define ATI_BIT_MULTI 0
`define ATI_BIT_CCMODE 4

`define ATI_EVT_W 3
`define ATI_CC_N 3
`define ATI_RST_EN 3'h0
`define ATI_RST_MODE 32'h0000_0000

`endif

// File: hw/ati_pkg.sv
/*
 * Types shared by the angular timer interrupt logic.
 * Assumes ati_regs.svh carries the register offsets, field positions and enable and mode reset values.
 */
package ati_pkg;
  typedef enum logic {
    ATI_SINGLE_PULSE = 1'b0,
    ATI_MULTI_PULSE = 1'b1
  } ati_pulse_mode_type;

  typedef enum logic {
    ATI_CC_COMPARE = 1'b0,
    ATI_CC_CAPTURE = 1'b1
  } ati_cc_mode_type;
endpackage : ati_pkg

// File: hw/ati_evt_if.sv
/*
 * One-cycle event pulses from the event generator to the flag logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface ati_evt_if;
  logic period_evt;
  logic phase_evt;
  logic missing_evt;
  logic [2:0] cc_evt;
  modport src (output period_evt, output phase_evt, output missing_evt, output cc_evt);
  modport dst (input period_evt, input phase_evt, input missing_evt, input cc_evt);
endinterface : ati_evt_if
`default_nettype wire

// File: hw/ati_flag_bank.sv
/*
 * Sticky flag group with write-one-to-clear and per-bit enables.
 * Assumes set and clear are single-cycle strobes on hclk.
 */
`timescale 1ns/100ps
`default_nettype none
module ati_flag_bank #(
  parameter int WIDTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] flags,
  output logic pending
);
  import ati_pkg::*;

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad
    $error("ati_flag_bank: WIDTH out of range");
  end

  // Set beats clear so an event in the clearing cycle survives
  assign flag_d = (flag_q & ~clr) | set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flags = flag_q;
  assign pending = |(flag_q & enable);
endmodule : ati_flag_bank
`default_nettype wire

// File: hw/ati_event_gen.sv
/*
 * Turns timer strobes into interrupt events: period, phase, missing
 * pulse, and capture/compare per channel. Assumes strobe inputs are
 * one-cycle pulses synchronous to hclk.
 */
`timescale 1ns/100ps
`default_nettype none
module ati_event_gen #(
  parameter int PHASE_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ati_pkg::ati_pulse_mode_type pulse_mode,
  input wire logic [2:0] cc_capture,
  input wire logic [3*PHASE_W-1:0] cmp_vals,
  input wire logic in_edge,
  input wire logic missed_pulse,
  input wire logic phase_clk,
  input wire logic [PHASE_W-1:0] phase_count,
  input wire logic [2:0] capture_sig,
  output logic [3*PHASE_W-1:0] cap_vals,
  output logic period_clk_out,
  ati_evt_if.src evt
);
  import ati_pkg::*;

  logic miss_pend_q;
  logic period_q;
  logic phase_q;
  logic missing_q;
  logic period_hit;

  if (PHASE_W < 1 || PHASE_W > 32) begin : g_bad
    $error("ati_event_gen: PHASE_W out of range");
  end

  // Multi-pulse: only the edge after a missed pulse counts
  assign period_hit = in_edge &&
    (pulse_mode == ATI_SINGLE_PULSE || miss_pend_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss_pend_q <= 1'b0;
    end else if (missed_pulse) begin
      miss_pend_q <= 1'b1;
    end else if (in_edge) begin
      miss_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_q <= 1'b0;
      phase_q <= 1'b0;
      missing_q <= 1'b0;
    end else begin
      period_q <= period_hit;
      phase_q <= phase_clk;
      missing_q <= missed_pulse;
    end
  end

  // Period clock pulse and period event come from one flop
  assign period_clk_out = period_q;
  assign evt.period_evt = period_q;
  assign evt.phase_evt = phase_q;
  assign evt.missing_evt = missing_q;

  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [PHASE_W-1:0] cap_q;
    logic done_q;
    logic match_q;
    logic match;
    assign match = (phase_count == cmp_vals[i*PHASE_W +: PHASE_W]);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cap_q <= '0;
        done_q <= 1'b0;
        match_q <= 1'b0;
      end else begin
        match_q <= match;
        if (cc_capture[i] && capture_sig[i]) begin
          cap_q <= phase_count;
        end
        // Flag on the same edge as the latch, so the value is already there
        if (cc_capture[i]) begin
          done_q <= capture_sig[i];
        end else begin
          // Rising match only; a stalled counter would refire forever
          done_q <= match && !match_q;
        end
      end
    end
    assign cap_vals[i*PHASE_W +: PHASE_W] = cap_q;
    assign evt.cc_evt[i] = done_q;
  end
endmodule : ati_event_gen
`default_nettype wire

// File: hw/ati_top.sv
/*
 * Angular timer interrupt logic: two enable/flag pairs, summary flag,
 * AHB-Lite register slave and level interrupt output.
 * Assumes a single AHB-Lite master and timer strobes on hclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ati_regs.svh"
module ati_top #(
  parameter int PHASE_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic in_edge,
  input wire logic missed_pulse,
  input wire logic phase_clk,
  input wire logic [PHASE_W-1:0] phase_count,
  input wire logic [2:0] capture_sig,
  output logic period_clk_out,
  output logic irq
);
  import ati_pkg::*;

  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic irq_q;
  logic [`ATI_EVT_W-1:0] evt_en_q;
  logic [`ATI_CC_N-1:0] cc_en_q;
  logic periph_en_q;
  logic [31:0] mode_q;
  logic [3*PHASE_W-1:0] cmp_q;
  logic [3*PHASE_W-1:0] cap_vals;
  logic [`ATI_EVT_W-1:0] evt_flags;
  logic [`ATI_CC_N-1:0] cc_flags;
  logic [`ATI_EVT_W-1:0] evt_set;
  logic [`ATI_EVT_W-1:0] evt_clr;
  logic [`ATI_CC_N-1:0] cc_clr;
  logic evt_pending;
  logic cc_pending;
  logic summary_flag;
  logic accept;
  logic wr_now;
  logic [31:0] rd_mux;
  ati_pulse_mode_type pulse_mode;

  ati_evt_if evt_bus ();

  if (PHASE_W < 1 || PHASE_W > 32) begin : g_bad
    $error("ati_top: PHASE_W out of range");
  end

  // AHB-Lite address phase
  assign accept = hsel && htrans[1] && hready;
  assign wr_now = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      if (accept) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // One wait state on reads so a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (accept && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else begin
        hreadyout_q <= 1'b1;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      `ATI_OFF_EVT_EN: rd_mux[`ATI_EVT_W-1:0] = evt_en_q;
      `ATI_OFF_EVT_FLAG: rd_mux[`ATI_EVT_W-1:0] = evt_flags;
      `ATI_OFF_CC_EN: rd_mux[`ATI_CC_N-1:0] = cc_en_q;
      `ATI_OFF_CC_FLAG: rd_mux[`ATI_CC_N-1:0] = cc_flags;
      `ATI_OFF_SUMMARY: rd_mux[`ATI_BIT_SUMMARY] = summary_flag;
      `ATI_OFF_PERIPH_EN: rd_mux[0] = periph_en_q;
      `ATI_OFF_MODE: rd_mux = mode_q;
      `ATI_OFF_CMP1: rd_mux[PHASE_W-1:0] = cmp_q[0 +: PHASE_W];
      `ATI_OFF_CMP2: rd_mux[PHASE_W-1:0] = cmp_q[PHASE_W +: PHASE_W];
      `ATI_OFF_CMP3: rd_mux[PHASE_W-1:0] = cmp_q[2*PHASE_W +: PHASE_W];
      `ATI_OFF_CAP1: rd_mux[PHASE_W-1:0] = cap_vals[0 +: PHASE_W];
      `ATI_OFF_CAP2: rd_mux[PHASE_W-1:0] = cap_vals[PHASE_W +: PHASE_W];
      `ATI_OFF_CAP3: rd_mux[PHASE_W-1:0] = cap_vals[2*PHASE_W +: PHASE_W];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Enable registers; the summary offset has no write path at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en_q <= `ATI_RST_EN;
      cc_en_q <= `ATI_RST_EN;
      periph_en_q <= 1'b0;
    end else if (wr_now) begin
      case (addr_q)
        `ATI_OFF_EVT_EN: evt_en_q <= hwdata[`ATI_EVT_W-1:0];
        `ATI_OFF_CC_EN: cc_en_q <= hwdata[`ATI_CC_N-1:0];
        `ATI_OFF_PERIPH_EN: periph_en_q <= hwdata[0];
        default: periph_en_q <= periph_en_q;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= `ATI_RST_MODE;
      cmp_q <= '0;
    end else if (wr_now) begin
      case (addr_q)
        `ATI_OFF_MODE: mode_q <= hwdata & 32'h0000_0071;
        `ATI_OFF_CMP1: cmp_q[0 +: PHASE_W] <= hwdata[PHASE_W-1:0];
        `ATI_OFF_CMP2: cmp_q[PHASE_W +: PHASE_W] <= hwdata[PHASE_W-1:0];
        `ATI_OFF_CMP3: cmp_q[2*PHASE_W +: PHASE_W] <= hwdata[PHASE_W-1:0];
        default: cmp_q <= cmp_q;
      endcase
    end
  end

  assign pulse_mode = ati_pulse_mode_type'(mode_q[`ATI_BIT_MULTI]);

  ati_event_gen #(
    .PHASE_W(PHASE_W)
  ) u_evt (
    .hclk(hclk),
    .hresetn(hresetn),
    .pulse_mode(pulse_mode),
    .cc_capture(mode_q[`ATI_BIT_CCMODE +: 3]),
    .cmp_vals(cmp_q),
    .in_edge(in_edge),
    .missed_pulse(missed_pulse),
    .phase_clk(phase_clk),
    .phase_count(phase_count),
    .capture_sig(capture_sig),
    .cap_vals(cap_vals),
    .period_clk_out(period_clk_out),
    .evt(evt_bus.src)
  );

  always_comb begin
    evt_set = '0;
    evt_set[`ATI_BIT_PERIOD] = evt_bus.period_evt;
    evt_set[`ATI_BIT_PHASE] = evt_bus.phase_evt;
    evt_set[`ATI_BIT_MISSING] = evt_bus.missing_evt;
  end

  // Write one to clear
  assign evt_clr = (wr_now && addr_q == `ATI_OFF_EVT_FLAG) ?
    hwdata[`ATI_EVT_W-1:0] : '0;
  assign cc_clr = (wr_now && addr_q == `ATI_OFF_CC_FLAG) ?
    hwdata[`ATI_CC_N-1:0] : '0;

  ati_flag_bank #(
    .WIDTH(`ATI_EVT_W)
  ) u_evt_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(evt_set),
    .clr(evt_clr),
    .enable(evt_en_q),
    .flags(evt_flags),
    .pending(evt_pending)
  );

  ati_flag_bank #(
    .WIDTH(`ATI_CC_N)
  ) u_cc_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(evt_bus.cc_evt),
    .clr(cc_clr),
    .enable(cc_en_q),
    .flags(cc_flags),
    .pending(cc_pending)
  );

  // Summary is derived, never stored, so software cannot desync it
  assign summary_flag = evt_pending || cc_pending;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= summary_flag && periph_en_q;
    end
  end

  assign irq = irq_q;
endmodule : ati_top
`default_nettype wire

// File: testbench/ati_top_sva.sv
/*
 * Concurrent checks on the ports of the angular timer interrupt logic.
 * Assumes a single AHB-Lite master and one clock, hclk.
 */
`timescale 1ns/100ps
`default_nettype none
module ati_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic in_edge,
  input wire logic period_clk_out,
  input wire logic irq
);
  logic tk;
  logic rd_tk;
  logic wr_q;
  logic seen_q;
  assign tk = hsel && htrans[1] && hready;
  assign rd_tk = tk && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= tk && hwrite;
  end

  // No enable can be set before the first write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) seen_q <= 1'b0;
    else seen_q <= seen_q || (tk && hwrite);
  end

  property p_resp_okay; hresp == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bad response");
  property p_rd_wait; rd_tk |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero; tk && hwrite |=> hreadyout; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_wait_cause; $fell(hreadyout) |-> $past(rd_tk); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stall without read");
  property p_rdata_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_period_src; period_clk_out |-> $past(in_edge); endproperty
  a_period_src: assert property (p_period_src) else $error("period pulse w/o edge");
  property p_irq_idle; !seen_q |-> !irq; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq before enable");
  property p_irq_sticky;
    $fell(irq) |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");

  c_read: cover property (rd_tk);
  c_irq: cover property ($rose(irq));
  c_period: cover property (period_clk_out);
endmodule : ati_top_chk

bind ati_top ati_top_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .in_edge, .period_clk_out, .irq);
`default_nettype wire

// File: testbench/ati_tmr_model.sv
/*
 * Behavioural angular timer core: strobes and a phase counter.
 * Assumes callers enter pulse right after a rising hclk edge.
 */
`timescale 1ns/100ps
`default_nettype none
module ati_tmr_model #(
  parameter int PHASE_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic in_edge,
  output logic missed_pulse,
  output logic phase_clk,
  output logic [PHASE_W-1:0] phase_count,
  output logic [2:0] capture_sig
);
  initial {capture_sig, phase_clk, missed_pulse, in_edge} = 6'h00;

  // Counter steps on each phase clock pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phase_count <= '0;
    else if (phase_clk) phase_count <= phase_count + 1'b1;
  end

  // s = {capture[2:0], phase, missed, edge}; one-cycle strobes
  task pulse(input logic [5:0] s);
    {capture_sig, phase_clk, missed_pulse, in_edge} <= s;
    @(posedge hclk);
    {capture_sig, phase_clk, missed_pulse, in_edge} <= 6'h00;
  endtask : pulse
endmodule : ati_tmr_model
`default_nettype wire

// File: testbench/angular_timer_interrupt_logic_test.sv
/*
 * Self-checking bench: AHB-Lite register access plus timer strobes.
 * Assumes the flag latency and one read wait state of the design.
 */
`timescale 1ns/100ps
`default_nettype none
module angular_timer_interrupt_logic_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, capture_sig;
  logic in_edge, missed_pulse, phase_clk, period_clk_out, irq;
  logic [15:0] phase_count;
  int bad_count = 0, tests_run = 0, cyc = 0, per = 0;

  ati_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .in_edge, .missed_pulse,
    .phase_clk, .phase_count, .capture_sig, .period_clk_out, .irq);
  ati_tmr_model m (.hclk, .hresetn, .in_edge, .missed_pulse, .phase_clk,
    .phase_count, .capture_sig);

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) if (period_clk_out === 1'b1) per++;
  // Whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Entered just after a rising edge; returns just after one
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : xfer

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd

  // Strobe, then let flag and irq settle
  task ev(input logic [5:0] s);
    m.pulse(s);
    repeat (4) @(posedge hclk);
  endtask : ev

  initial begin
    hclk = 0;
    hresetn = 0;
    hsel = 1;
    htrans = 2'b00;
    haddr = 0;
    hwrite = 0;
    hwdata = 0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) if (i != 3) rd(i * 4, 32'h0);
    rd(32'h3c, 32'h0);
    // Counter and compare values both start at zero
    rd(32'h0c, 32'h7);
    wr(32'h00, 32'h7);
    rd(32'h00, 32'h7);
    wr(32'h08, 32'h7);
    rd(32'h08, 32'h7);
    wr(32'h0c, 32'h7);
    ev(6'h01);
    rd(32'h04, 32'h1);
    chk(per, 1);
    rd(32'h10, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(32'h14, 32'h1);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(32'h10, 32'h0);
    rd(32'h10, 32'h1);
    ev(6'h04);
    rd(32'h04, 32'h3);
    ev(6'h02);
    rd(32'h04, 32'h7);
    wr(32'h04, 32'h1);
    rd(32'h04, 32'h6);
    wr(32'h04, 32'h6);
    rd(32'h04, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(32'h18, 32'h1);
    // Miss seen earlier is still armed
    ev(6'h01);
    rd(32'h04, 32'h1);
    wr(32'h04, 32'h1);
    ev(6'h01);
    rd(32'h04, 32'h0);
    ev(6'h02);
    ev(6'h01);
    rd(32'h04, 32'h5);
    chk(per, 3);
    wr(32'h04, 32'h7);
    // Capture on channel two with the counter at one
    wr(32'h18, 32'h70);
    ev(6'h10);
    rd(32'h0c, 32'h2);
    rd(32'h34, 32'h1);
    rd(32'h04, 32'h0);
    wr(32'h0c, 32'h7);
    wr(32'h18, 32'h0);
    wr(32'h20, 32'h2);
    ev(6'h04);
    rd(32'h0c, 32'h1);
    wr(32'h04, 32'h7);
    rd(32'h10, 32'h1);
    wr(32'h08, 32'h6);
    rd(32'h10, 32'h0);
    rd(32'h0c, 32'h1);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule : angular_timer_interrupt_logic_test
`default_nettype wire
